/* pdm_ctrl.sv */
// power-down mode controller: sleep, software standby and hardware standby
`timescale 1ns/1ns
module pdm_ctrl #(
  parameter logic [pdm_pkg::PDM_CNT_W-1:0] SETTLE_MIN_CYC = pdm_pkg::PDM_SETTLE_MIN_STATES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic sleep_exec_i,
  input wire logic standby_select_bit_i,
  input wire logic [2:0] settle_sel_i,
  input wire logic irq_wake_i,
  input wire logic nmi_n_i,
  input wire logic [2:0] ext_irq_n_i,
  input wire logic reset_in_pin_n_i,
  input wire logic hw_standby_pin_n_i,
  output logic cpu_halt_o,
  output logic sys_clk_en_o,
  output logic periph_init_o,
  output logic cpu_reg_clear_o,
  output logic port_hiz_o,
  output logic cpu_reset_o,
  output logic wake_irq_o,
  output logic standby_select_clear_o,
  output logic [5:0] mode_o
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    pdm_pkg::pdm_state_t st;
    logic cpu_halt;
    logic clk_en;
    logic periph_init;
    logic reg_clear;
    logic port_hiz;
    logic cpu_reset;
    logic wake_irq;
    logic sel_clear;
    logic tmr_start;
  } pdm_ctrl_t;

  pdm_ctrl_t ctl_reg;
  pdm_ctrl_t ctl_next;
  logic settle_done;
  logic sw_wake;

  // settling wait doubles per select code, saturating at the top code
  function automatic logic [pdm_pkg::PDM_CNT_W-1:0] settle_cycles(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > pdm_pkg::PDM_STS_MAX) ? pdm_pkg::PDM_STS_MAX : sel;
    settle_cycles = SETTLE_MIN_CYC << s;
  endfunction

  // only the three low external requests and NMI may wake software standby
  assign sw_wake = !nmi_n_i || (ext_irq_n_i != 3'h7);

  // ----------------------------------------------------------------
  // next state and outputs
  // ----------------------------------------------------------------
  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.wake_irq = 1'b0;
    ctl_next.sel_clear = 1'b0;
    ctl_next.tmr_start = 1'b0;
    if (!hw_standby_pin_n_i) begin
      ctl_next.st = pdm_pkg::PDM_ST_HWSTBY;
    end else begin
      case (ctl_reg.st)
        pdm_pkg::PDM_ST_RUN: begin
          if (!reset_in_pin_n_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_RESET;
          end else if (sleep_exec_i && standby_select_bit_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_SWSTBY;
          end else if (sleep_exec_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_SLEEP;
          end
        end
        pdm_pkg::PDM_ST_SLEEP: begin
          if (!reset_in_pin_n_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_RESET;
          end else if (irq_wake_i || !nmi_n_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_RUN;
            ctl_next.wake_irq = 1'b1;
          end
        end
        pdm_pkg::PDM_ST_SWSTBY: begin
          if (!reset_in_pin_n_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_RESET;
          end else if (sw_wake) begin
            ctl_next.st = pdm_pkg::PDM_ST_SETTLE;
            ctl_next.tmr_start = 1'b1;
          end
        end
        pdm_pkg::PDM_ST_SETTLE: begin
          if (!reset_in_pin_n_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_RESET;
          end else if (settle_done) begin
            ctl_next.st = pdm_pkg::PDM_ST_RUN;
            ctl_next.wake_irq = 1'b1;
          end
        end
        pdm_pkg::PDM_ST_HWSTBY: begin
          // pin already high here; only a reset pulse leaves
          if (!reset_in_pin_n_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_RESET;
          end
        end
        pdm_pkg::PDM_ST_RESET: begin
          if (reset_in_pin_n_i) begin
            ctl_next.st = pdm_pkg::PDM_ST_RUN;
            ctl_next.sel_clear = 1'b1;
          end
        end
        default: begin
          ctl_next.st = pdm_pkg::PDM_ST_RESET;
        end
      endcase
    end
    // outputs follow the next state so they line up with the state register
    ctl_next.cpu_halt = (ctl_next.st != pdm_pkg::PDM_ST_RUN);
    ctl_next.clk_en = (ctl_next.st == pdm_pkg::PDM_ST_RUN) || (ctl_next.st == pdm_pkg::PDM_ST_SLEEP)
                      || (ctl_next.st == pdm_pkg::PDM_ST_RESET);
    ctl_next.periph_init = (ctl_next.st == pdm_pkg::PDM_ST_SWSTBY) || (ctl_next.st == pdm_pkg::PDM_ST_SETTLE)
                           || (ctl_next.st == pdm_pkg::PDM_ST_HWSTBY)
                           || (ctl_next.st == pdm_pkg::PDM_ST_RESET);
    ctl_next.reg_clear = (ctl_next.st == pdm_pkg::PDM_ST_HWSTBY);
    ctl_next.port_hiz = (ctl_next.st == pdm_pkg::PDM_ST_HWSTBY);
    ctl_next.cpu_reset = (ctl_next.st == pdm_pkg::PDM_ST_RESET);
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_reg <= '{st: pdm_pkg::PDM_ST_RESET, cpu_halt: 1'b1, clk_en: 1'b1, periph_init: 1'b1,
                   reg_clear: 1'b0, port_hiz: 1'b0, cpu_reset: 1'b1, wake_irq: 1'b0,
                   sel_clear: 1'b0, tmr_start: 1'b0};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // ----------------------------------------------------------------
  // settling timer
  // ----------------------------------------------------------------
  pdm_settle_timer u_settle (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .start_i(ctl_reg.tmr_start),
    .abort_i(ctl_reg.st != pdm_pkg::PDM_ST_SETTLE),
    .load_i(settle_cycles(settle_sel_i)),
    .done_o(settle_done)
  );

  assign cpu_halt_o = ctl_reg.cpu_halt;
  assign sys_clk_en_o = ctl_reg.clk_en;
  assign periph_init_o = ctl_reg.periph_init;
  assign cpu_reg_clear_o = ctl_reg.reg_clear;
  assign port_hiz_o = ctl_reg.port_hiz;
  assign cpu_reset_o = ctl_reg.cpu_reset;
  assign wake_irq_o = ctl_reg.wake_irq;
  assign standby_select_clear_o = ctl_reg.sel_clear;
  assign mode_o = ctl_reg.st;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  AST_SLEEP_OUTPUTS: assert property (
    mode_o == pdm_pkg::PDM_ST_SLEEP |-> cpu_halt_o && sys_clk_en_o && !periph_init_o && !port_hiz_o)
    else $error("sleep must halt only the cpu");
  AST_SWSTBY_OUTPUTS: assert property (
    mode_o == pdm_pkg::PDM_ST_SWSTBY |-> cpu_halt_o && !sys_clk_en_o && !cpu_reg_clear_o && !port_hiz_o)
    else $error("software standby must stop clock and keep registers");
  AST_HW_ENTRY: assert property (
    !hw_standby_pin_n_i |=> mode_o == pdm_pkg::PDM_ST_HWSTBY && port_hiz_o)
    else $error("standby pin low must enter hardware standby next cycle");
  AST_HW_STANDBY_PIN_INIT: assert property (
    (mode_o == pdm_pkg::PDM_ST_SWSTBY || mode_o == pdm_pkg::PDM_ST_HWSTBY) |-> periph_init_o)
    else $error("modules must be held initialised in standby");
  AST_SLEEP_ENTER: assert property (
    mode_o == pdm_pkg::PDM_ST_RUN && sleep_exec_i && !standby_select_bit_i && reset_in_pin_n_i
    && hw_standby_pin_n_i |=> mode_o == pdm_pkg::PDM_ST_SLEEP)
    else $error("sleep instruction with select clear must enter sleep");
  AST_SWSTBY_CAUSE: assert property (
    $rose(mode_o == pdm_pkg::PDM_ST_SWSTBY) |-> $past(sleep_exec_i) && $past(standby_select_bit_i))
    else $error("software standby entered without select bit and sleep");
  AST_SLEEP_WAKE: assert property (
    mode_o == pdm_pkg::PDM_ST_SLEEP && irq_wake_i && reset_in_pin_n_i && hw_standby_pin_n_i
    |=> mode_o == pdm_pkg::PDM_ST_RUN && wake_irq_o && !cpu_halt_o)
    else $error("interrupt must wake sleep next cycle");
  AST_SWSTBY_HOLD: assert property (
    mode_o == pdm_pkg::PDM_ST_SWSTBY && !sw_wake && reset_in_pin_n_i && hw_standby_pin_n_i
    |=> mode_o == pdm_pkg::PDM_ST_SWSTBY)
    else $error("software standby left without a wake pin");
  AST_SETTLE_RUN: assert property (
    mode_o == pdm_pkg::PDM_ST_SETTLE ##1 mode_o == pdm_pkg::PDM_ST_RUN |-> $past(settle_done))
    else $error("settling ended before timer expiry");
  AST_HW_EXIT: assert property (
    mode_o == pdm_pkg::PDM_ST_HWSTBY && reset_in_pin_n_i |=> mode_o == pdm_pkg::PDM_ST_HWSTBY
    && cpu_reg_clear_o)
    else $error("hardware standby left without reset pulse");

  COV_SLEEP_WAKE: cover property (
    mode_o == pdm_pkg::PDM_ST_SLEEP ##1 mode_o == pdm_pkg::PDM_ST_RUN);
  COV_SW_SETTLE: cover property (
    mode_o == pdm_pkg::PDM_ST_SETTLE ##1 mode_o == pdm_pkg::PDM_ST_RUN);
  COV_HW_RESET: cover property (
    mode_o == pdm_pkg::PDM_ST_HWSTBY ##1 mode_o == pdm_pkg::PDM_ST_RESET ##[1:20] mode_o == pdm_pkg::PDM_ST_RUN);

endmodule // pdm_ctrl

/* pdm_ext_model.sv */
// model of the outside logic that drives standby, reset and wake-up pins
`timescale 1ns/1ns
module pdm_ext_model (
  input wire logic clk_sys_i,
  input wire logic [6:0] pins_i,
  output logic irq_wake_o,
  output logic nmi_n_o,
  output logic [2:0] ext_irq_n_o,
  output logic reset_n_o,
  output logic hw_standby_n_o
);
  // pins_i = {irq_wake, nmi_n, ext_irq_n[2:0], reset_n, hw_standby_n}
  // the board moves its pins on an edge, so the design takes a request one edge later
  // standby is asked for by a low pin; leaving it is pin high first, then a reset pulse
  always @(posedge clk_sys_i) begin
    {irq_wake_o, nmi_n_o, ext_irq_n_o, reset_n_o, hw_standby_n_o} <= pins_i;
  end
endmodule // pdm_ext_model

/* pdm_pkg.sv */
// package of constants and types for the power-down mode controller
package pdm_pkg;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    PDM_ST_RUN    = 6'h01,
    PDM_ST_SLEEP  = 6'h02,
    PDM_ST_SWSTBY = 6'h04,
    PDM_ST_SETTLE = 6'h08,
    PDM_ST_HWSTBY = 6'h10,
    PDM_ST_RESET  = 6'h20
  } pdm_state_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PDM_CNT_W = 18;
  // shortest oscillator settling time, in states (one state = one clock)
  localparam logic [PDM_CNT_W-1:0] PDM_SETTLE_MIN_STATES = 18'h02000;
  // largest settling select code; codes above it mean the same
  localparam logic [2:0] PDM_STS_MAX = 3'h4;

endpackage

/* pdm_settle_timer.sv */
// one-shot down-counter that times the oscillator settling wait
`timescale 1ns/1ns
module pdm_settle_timer (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [pdm_pkg::PDM_CNT_W-1:0] load_i,
  output logic done_o
);

  typedef struct packed {
    logic busy;
    logic [pdm_pkg::PDM_CNT_W-1:0] cnt;
    logic done;
  } pdm_tmr_t;

  pdm_tmr_t tmr_reg;
  pdm_tmr_t tmr_next;

  always_comb begin
    tmr_next = tmr_reg;
    tmr_next.done = 1'b0;
    if (abort_i) begin
      tmr_next.busy = 1'b0;
    end else if (start_i) begin
      tmr_next.busy = 1'b1;
      tmr_next.cnt = load_i - 18'h00001;
    end else if (tmr_reg.busy) begin
      if (tmr_reg.cnt == 18'h00000) begin
        tmr_next.busy = 1'b0;
        tmr_next.done = 1'b1;
      end else begin
        tmr_next.cnt = tmr_reg.cnt - 18'h00001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign done_o = tmr_reg.done;

endmodule // pdm_settle_timer

/* power_down_mode_control_test.sv */
// self-checking testbench of the power-down mode controller
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module power_down_mode_control_test;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sleep_exec = 1'b0;
  logic sel_bit = 1'b0;
  logic [2:0] settle_sel = 3'h0;
  // far-side pins {irq_wake, nmi_n, ext_irq_n[2:0], reset_n, hw_standby_n}, idle
  logic [6:0] ext_pins = 7'h3F;
  logic irq_w, nmi_n, res_n, hw_standby_pin_n, halt, clk_en, p_init, reg_clr, hiz, c_rst, wake, sel_clr;
  logic [2:0] ext_n;
  logic [5:0] mode;
  int error_cnt = 0;
  int n_compared = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  pdm_ext_model pdm_ext_model_inst (.clk_sys_i(clk_sys_i), .pins_i(ext_pins), .irq_wake_o(irq_w), .nmi_n_o(nmi_n),
    .ext_irq_n_o(ext_n), .reset_n_o(res_n), .hw_standby_n_o(hw_standby_pin_n));
  // short settling base keeps the 16x case to a few dozen cycles
  pdm_ctrl #(.SETTLE_MIN_CYC(18'h00004)) pdm_ctrl_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .sleep_exec_i(sleep_exec), .standby_select_bit_i(sel_bit), .settle_sel_i(settle_sel),
    .irq_wake_i(irq_w), .nmi_n_i(nmi_n), .ext_irq_n_i(ext_n), .reset_in_pin_n_i(res_n),
    .hw_standby_pin_n_i(hw_standby_pin_n), .cpu_halt_o(halt), .sys_clk_en_o(clk_en), .periph_init_o(p_init),
    .cpu_reg_clear_o(reg_clr), .port_hiz_o(hiz), .cpu_reset_o(c_rst), .wake_irq_o(wake),
    .standby_select_clear_o(sel_clr), .mode_o(mode));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // hand the far side new pin levels; they reach the design one edge later
  task automatic pins(input logic [6:0] v);
    ext_pins = v;
    cyc(1);
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one-cycle sleep instruction with the select bit as given
  task automatic sleep_instr(input logic sel);
    sel_bit = sel;
    sleep_exec = 1'b1;
    cyc(1);
    sleep_exec = 1'b0;
  endtask
  task automatic t_sleep;
    sleep_instr(1'b0);
    `CHK({mode, halt, clk_en, p_init}, {6'h02, 3'h6})
    pins(7'h7F);
    cyc(1);
    `CHK({mode, halt, wake}, {6'h01, 2'h1})
    cyc(1);
    `CHK(wake, 1'b0)
    pins(7'h3F);
    // nmi alone must wake sleep as well
    sleep_instr(1'b0);
    pins(7'h1F);
    cyc(1);
    `CHK({mode, halt, wake}, {6'h01, 2'h1})
    pins(7'h3F);
    $display("test sleep done");
  endtask
  // software standby, woken by the given pins, settling n cycles
  task automatic t_swstby(input logic [2:0] sel, input logic [6:0] wake_pins, input int n);
    settle_sel = sel;
    sleep_instr(1'b1);
    `CHK({mode, halt, clk_en, p_init}, {6'h04, 3'h5})
    pins(7'h7F);
    cyc(1);
    `CHK(mode, 6'h04)
    pins(wake_pins);
    cyc(1);
    `CHK(mode, 6'h08)
    pins(7'h3F);
    // the timer loads one edge after entry and its done pulse is taken one edge late
    cyc(n);
    `CHK({mode, clk_en, p_init}, {6'h08, 2'h1})
    cyc(1);
    `CHK({mode, clk_en, p_init, wake, halt}, {6'h01, 4'hA})
    sel_bit = 1'b0;
    settle_sel = 3'h0;
    $display("test software standby done");
  endtask
  // reset pin low leaves sleep (sel 0) or software standby (sel 1) for the reset state
  task automatic t_pin_reset(input logic sel);
    sleep_instr(sel);
    `CHK({mode, clk_en}, sel ? 7'h08 : 7'h05)
    pins(7'h3D);
    cyc(1);
    `CHK({mode, c_rst, p_init, halt}, {6'h20, 3'h7})
    cyc(1);
    `CHK({mode, sel_clr}, {6'h20, 1'b0})
    pins(7'h3F);
    cyc(1);
    `CHK({mode, sel_clr, c_rst}, {6'h01, 2'h2})
    cyc(1);
    `CHK(sel_clr, 1'b0)
    sel_bit = 1'b0;
    $display("test reset pin exit done");
  endtask
  // system reset in mid-run, taken from sleep
  task automatic t_sys_reset;
    sleep_instr(1'b0);
    sys_rst_i = 1'b1;
    #1;
    `CHK({mode, p_init, c_rst}, {6'h20, 2'h3})
    cyc(2);
    sys_rst_i = 1'b0;
    `CHK({mode, p_init}, {6'h20, 1'b1})
    cyc(1);
    `CHK({mode, p_init, sel_clr}, {6'h01, 2'h1})
    cyc(1);
    `CHK({mode, halt}, {6'h01, 1'b0})
    $display("test system reset done");
  endtask
  // entered from sleep; only pin high then a reset pulse leaves it
  task automatic t_hwstby;
    sleep_instr(1'b0);
    pins(7'h3E);
    cyc(1);
    `CHK({mode, hiz, reg_clr, p_init, clk_en}, {6'h10, 4'hE})
    pins(7'h23);
    cyc(1);
    `CHK(mode, 6'h10)
    pins(7'h3D);
    cyc(1);
    `CHK({mode, c_rst, hiz}, {6'h20, 2'h2})
    pins(7'h3F);
    cyc(1);
    `CHK({mode, sel_clr, c_rst}, {6'h01, 2'h2})
    $display("test hardware standby done");
  endtask
  initial begin
    cyc(6);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 10 && mode !== 6'h01; i++)
      cyc(1);
    if (mode !== 6'h01) begin
      error_cnt++;
      report_and_stop();
    end
    t_sleep();
    t_swstby(3'h1, 7'h3B, 8);
    // codes above the top select behave as the top one: 16x
    t_swstby(3'h6, 7'h1F, 64);
    t_swstby(3'h3, 7'h2F, 32);
    t_swstby(3'h0, 7'h37, 4);
    t_pin_reset(1'b0);
    t_pin_reset(1'b1);
    t_sys_reset();
    t_hwstby();
    report_and_stop();
  end
endmodule // power_down_mode_control_test
